// [bcg_defs.svh]
// timing counts, codes and reset values for the calibration and gain block
`ifndef BCG_DEFS_SVH
`define BCG_DEFS_SVH
`define BCG_CLK_HZ          100000000
`define BCG_PRF_4MHZ_HZ     4000000
`define BCG_PRF_2MHZ_HZ     2000000
`define BCG_PRF_1MHZ_HZ     1000000
`define BCG_PRF_500KHZ_HZ   500000
`define BCG_PRF_250KHZ_HZ   250000
`define BCG_DIV_4MHZ        (`BCG_CLK_HZ / `BCG_PRF_4MHZ_HZ)
`define BCG_DIV_2MHZ        (`BCG_CLK_HZ / `BCG_PRF_2MHZ_HZ)
`define BCG_DIV_1MHZ        (`BCG_CLK_HZ / `BCG_PRF_1MHZ_HZ)
`define BCG_DIV_500KHZ      (`BCG_CLK_HZ / `BCG_PRF_500KHZ_HZ)
`define BCG_DIV_250KHZ      (`BCG_CLK_HZ / `BCG_PRF_250KHZ_HZ)
`define BCG_RATE_MAX        3'h4
`define BCG_RATE_RST        3'h2
`define BCG_INT_LEN_RST     8'h50
`define BCG_GAIN_RST        5'h14
`define BCG_A_UNITY_BIT     4
`define BCG_A_TENTH_BIT     3
`define BCG_B_UNITY_BIT     2
`define BCG_B_TENTH_BIT     1
`define BCG_BOTH_TENFOLD_BIT 0
`endif

// [bcg_pkg.sv]
// types shared by the calibration and gain block
package bcg_pkg;
    typedef enum logic [1:0] {
        BCG_FO_TENTH   = 2'b00,
        BCG_FO_UNITY   = 2'b01,
        BCG_FO_FIVE    = 2'b10,
        BCG_FO_FIFTY   = 2'b11
    } bcg_fo_gain_t;
    typedef enum logic [0:0] {
        BCG_ST_IDLE  = 1'b0,
        BCG_ST_BURST = 1'b1
    } bcg_state_t;
endpackage : bcg_pkg

// [bcg_rate_div.sv]
// divider that makes the calibration pulse enable at the selected rate
`timescale 1ns/10ps
`include "bcg_defs.svh"
module bcg_rate_div
(
    input  wire logic       clock_i,
    input  wire logic       reset_n_i,
    input  wire logic       run_i,
    input  wire logic [2:0] rate_i,
    output logic            tick_o
);
    import bcg_pkg::*;

    // full period table; 250 kHz needs 400 cycles so count is wider
    logic [8:0] cyc_reg;
    logic [8:0] cyc_top;
    always_comb
    begin
        unique case (rate_i)
            3'h0:    cyc_top = 9'(`BCG_DIV_4MHZ - 1);
            3'h1:    cyc_top = 9'(`BCG_DIV_2MHZ - 1);
            3'h2:    cyc_top = 9'(`BCG_DIV_1MHZ - 1);
            3'h3:    cyc_top = 9'(`BCG_DIV_500KHZ - 1);
            default: cyc_top = 9'(`BCG_DIV_250KHZ - 1);
        endcase
    end
    // restarts while idle so the first pulse of a burst comes at once
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            cyc_reg <= 9'h0;
        else if (!run_i || cyc_reg >= cyc_top)
            cyc_reg <= 9'h0;
        else
            cyc_reg <= cyc_reg + 9'h1;
    end

    assign tick_o = run_i && (cyc_reg == 9'h0);
endmodule : bcg_rate_div

// [bcg_cal_gain.sv]
// calibration burst timing and front-end gain decoding for one station
// Notes on behaviour
// - hold cal mode and rate code 0..4
// - codes 0..4 give 4M,2M,1M,500k,250k
// - hold integration length 1..255 bunches
// - integration counts bunches, not turns
// - cal burst pulse count equals length
// - cal mode makes restorer pulses locally
// - one bit picks normal or single-turn capacitance
// - separate fiberoptic pre-amp gain select
// - five-bit word maps to channel enables
// - word 20 gives unity on both
// - word 21 gives x10 on both
// - word 10 gives tenth on both
// - each channel settable alone
// - all-clear channel gates its input off
// - shared stations ignore broadcast settings
`timescale 1ns/10ps
`include "bcg_defs.svh"
module bcg_cal_gain
(
    input  wire logic                clock_i,
    input  wire logic                reset_n_i,
    input  wire logic                shared_station_i,
    input  wire logic                set_strobe_i,
    input  wire logic                set_broadcast_i,
    input  wire logic                cal_on_i,
    input  wire logic [2:0]          cal_rate_i,
    input  wire logic [7:0]          int_length_i,
    input  wire logic [4:0]          gain_word_i,
    input  wire logic                single_turn_i,
    input  wire bcg_pkg::bcg_fo_gain_t fo_gain_i,
    input  wire logic                start_i,
    input  wire logic                bunch_i,
    input  wire logic                ext_restore_i,
    output logic                     cal_pulse_o,
    output logic                     restore_o,
    output logic                     int_active_o,
    output logic                     burst_busy_o,
    output logic                     cal_mode_o,
    output logic [2:0]               cal_rate_o,
    output logic [7:0]               int_length_o,
    output logic                     a_unity_en_o,
    output logic                     a_tenth_en_o,
    output logic                     b_unity_en_o,
    output logic                     b_tenth_en_o,
    output logic                     tenfold_en_o,
    output logic                     a_input_on_o,
    output logic                     b_input_on_o,
    output logic                     single_turn_gain_o,
    output bcg_pkg::bcg_fo_gain_t    fo_gain_o
);
    import bcg_pkg::*;

    logic         cal_mode_reg;
    logic [2:0]   rate_reg;
    logic [7:0]   len_reg;
    logic [4:0]   gain_reg;
    logic         st_reg;
    bcg_fo_gain_t fo_reg;
    bcg_state_t   state_reg;
    logic [7:0]   left_reg;
    logic         tick;
    logic         accept;
    logic         run;
    logic         pulse_reg;
    logic         restore_reg;

    // a broadcast write never reaches a shared station
    assign accept = set_strobe_i && !(set_broadcast_i && shared_station_i);

    // settings written by the host
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cal_mode_reg <= 1'b0;
            len_reg      <= `BCG_INT_LEN_RST;
            gain_reg     <= `BCG_GAIN_RST;
            st_reg       <= 1'b0;
            fo_reg       <= BCG_FO_UNITY;
        end
        else if (accept)
        begin
            cal_mode_reg <= cal_on_i;
            if (int_length_i != 8'h0)
                len_reg <= int_length_i;
            gain_reg     <= gain_word_i;
            st_reg       <= single_turn_i;
            fo_reg       <= fo_gain_i;
        end
    end

    // undefined codes keep the last good rate
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rate_reg <= `BCG_RATE_RST;
        else if (accept && cal_rate_i <= `BCG_RATE_MAX)
            rate_reg <= cal_rate_i;
    end

    assign run = (state_reg == BCG_ST_BURST);

    bcg_rate_div u_div
    (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .run_i     (run),
        .rate_i    (rate_reg),
        .tick_o    (tick)
    );

    // burst and integration sequencing; a start while busy is ignored
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= BCG_ST_IDLE;
            left_reg  <= 8'h0;
        end
        else
        begin
            unique case (state_reg)
                BCG_ST_IDLE:
                begin
                    if (start_i)
                    begin
                        state_reg <= BCG_ST_BURST;
                        left_reg  <= len_reg;
                    end
                end
                BCG_ST_BURST:
                begin
                    // in cal mode each test pulse is one bunch
                    if (cal_mode_reg ? tick : bunch_i)
                    begin
                        left_reg <= left_reg - 8'h1;
                        if (left_reg == 8'h1)
                            state_reg <= BCG_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // registered pulse and restorer outputs
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pulse_reg   <= 1'b0;
            restore_reg <= 1'b0;
        end
        else
        begin
            pulse_reg   <= cal_mode_reg && run && tick;
            // local restorer shares the test pulse edge for phase
            restore_reg <= cal_mode_reg ? (run && tick)
                                        : ext_restore_i;
        end
    end

    assign cal_pulse_o        = pulse_reg;
    assign restore_o          = restore_reg;
    assign int_active_o       = run;
    assign burst_busy_o       = run && cal_mode_reg;
    assign cal_mode_o         = cal_mode_reg;
    assign cal_rate_o         = rate_reg;
    assign int_length_o       = len_reg;
    // straight bit map gives 20, 21, 10 and one-sided codes for free
    assign a_unity_en_o       = gain_reg[`BCG_A_UNITY_BIT];
    assign a_tenth_en_o       = gain_reg[`BCG_A_TENTH_BIT];
    assign b_unity_en_o       = gain_reg[`BCG_B_UNITY_BIT];
    assign b_tenth_en_o       = gain_reg[`BCG_B_TENTH_BIT];
    assign tenfold_en_o       = gain_reg[`BCG_BOTH_TENFOLD_BIT];
    // a channel with neither own bit set has its input gated
    assign a_input_on_o       = gain_reg[`BCG_A_UNITY_BIT]
                              | gain_reg[`BCG_A_TENTH_BIT];
    assign b_input_on_o       = gain_reg[`BCG_B_UNITY_BIT]
                              | gain_reg[`BCG_B_TENTH_BIT];
    assign single_turn_gain_o = st_reg;
    assign fo_gain_o          = fo_reg;
endmodule : bcg_cal_gain

// [bcg_cal_gain_checker.sv]
// port assertions for the calibration and gain block
`timescale 1ns/10ps
module bcg_cal_gain_checker
(
    input wire logic       clock_i,
    input wire logic       reset_n_i,
    input wire logic       shared_station_i,
    input wire logic       set_strobe_i,
    input wire logic       set_broadcast_i,
    input wire logic [2:0] cal_rate_i,
    input wire logic [7:0] int_length_i,
    input wire logic [4:0] gain_word_i,
    input wire logic       start_i,
    input wire logic       cal_pulse_o,
    input wire logic       restore_o,
    input wire logic       int_active_o,
    input wire logic       cal_mode_o,
    input wire logic [2:0] cal_rate_o,
    input wire logic [7:0] int_length_o,
    input wire logic       a_unity_en_o,
    input wire logic       a_tenth_en_o,
    input wire logic       b_unity_en_o,
    input wire logic       b_tenth_en_o,
    input wire logic       tenfold_en_o,
    input wire logic       a_input_on_o
);
    logic acc;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    // a write that the station really takes
    assign acc = set_strobe_i && !(set_broadcast_i && shared_station_i);
    property p_rate;
        acc && cal_rate_i <= 3'h4 |=> cal_rate_o == $past(cal_rate_i);
    endproperty
    a_rate: assert property (p_rate)
        else $error("rate code not applied");
    property p_bad_rate;
        set_strobe_i && cal_rate_i > 3'h4 |=> $stable(cal_rate_o);
    endproperty
    a_bad_rate: assert property (p_bad_rate)
        else $error("undefined rate code applied");
    property p_gain;
        acc |=> {a_unity_en_o, a_tenth_en_o, b_unity_en_o, b_tenth_en_o,
                 tenfold_en_o} == $past(gain_word_i);
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain enables differ from word");
    property p_shared;
        set_strobe_i && set_broadcast_i && shared_station_i
            |=> $stable(int_length_o) && $stable(cal_mode_o);
    endproperty
    a_shared: assert property (p_shared)
        else $error("broadcast changed a shared station");
    property p_len0;
        set_strobe_i && int_length_i == 8'h00 |=> $stable(int_length_o);
    endproperty
    a_len0: assert property (p_len0)
        else $error("zero length taken");
    property p_gate;
        a_input_on_o == (a_unity_en_o || a_tenth_en_o);
    endproperty
    a_gate: assert property (p_gate)
        else $error("input gate wrong");
    property p_prf;
        cal_pulse_o && int_active_o && cal_rate_o == 3'h0
            |-> ##25 cal_pulse_o;
    endproperty
    a_prf: assert property (p_prf)
        else $error("4 MHz spacing wrong");
    property p_local;
        cal_mode_o && $past(cal_mode_o) |-> restore_o == cal_pulse_o;
    endproperty
    a_local: assert property (p_local)
        else $error("restorer not local in cal mode");
    property p_start;
        start_i && !int_active_o |=> int_active_o;
    endproperty
    a_start: assert property (p_start)
        else $error("window did not open");
endmodule : bcg_cal_gain_checker
bind bcg_cal_gain bcg_cal_gain_checker i_bcg_cal_gain_checker (.*);

// [bcg_front_end_model.sv]
// bunch train and external restorer source for the block
`timescale 1ns/10ps
module bcg_front_end_model #(parameter int GAP = 8)
(
    input  wire logic clock_i,
    input  wire logic reset_n_i,
    output logic      bunch_o,
    output logic      restore_o
);
    logic [7:0] cnt_reg;
    // one bunch every GAP cycles, restorer one cycle later
    always_ff @(posedge clock_i or negedge reset_n_i)
        if (!reset_n_i)
        begin
            cnt_reg <= 8'h00;
            bunch_o <= 1'b0;
            restore_o <= 1'b0;
        end
        else
        begin
            cnt_reg <= (cnt_reg == 8'(GAP - 1)) ? 8'h00 : cnt_reg + 8'h01;
            bunch_o <= (cnt_reg == 8'(GAP - 1));
            restore_o <= bunch_o;
        end
endmodule : bcg_front_end_model

// [bcg_cal_gain_tb.sv]
// self-checking bench for the calibration and gain block
`timescale 1ns/10ps
`include "bcg_defs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
    $display("unexpected at %0t: mismatch line %0d", $time, `__LINE__); end end
module bcg_cal_gain_tb;
    import bcg_pkg::*;
    logic clock_i = 0, reset_n_i = 0, shared_station_i = 0, set_strobe_i = 0;
    logic set_broadcast_i = 0, cal_on_i = 0, single_turn_i = 0, start_i = 0;
    logic [2:0] cal_rate_i = 0;
    logic [7:0] int_length_i = 0;
    logic [4:0] gain_word_i = 0;
    bcg_fo_gain_t fo_gain_i = BCG_FO_TENTH;
    logic bunch_i, ext_restore_i, cal_pulse_o, restore_o, int_active_o;
    logic burst_busy_o, cal_mode_o, a_unity_en_o, a_tenth_en_o, b_unity_en_o;
    logic b_tenth_en_o, tenfold_en_o, a_input_on_o, b_input_on_o;
    logic single_turn_gain_o;
    logic [2:0] cal_rate_o;
    logic [7:0] int_length_o;
    bcg_fo_gain_t fo_gain_o;
    int failures = 0, comparisons = 0;
    logic [4:0] words [10] = '{5'h0a, 5'h14, 5'h15, 5'h10, 5'h04,
                               5'h11, 5'h05, 5'h08, 5'h02, 5'h00};
    bcg_cal_gain i_bcg_cal_gain (.*);
    bcg_front_end_model i_bcg_front_end_model (.clock_i(clock_i),
        .reset_n_i(reset_n_i), .bunch_o(bunch_i), .restore_o(ext_restore_i));
    initial forever #5 clock_i = ~clock_i;
    // one settings write, outputs visible on return
    task automatic put(input logic [2:0] r, input logic [7:0] l,
                       input logic [4:0] g, input logic bc);
        @(negedge clock_i);
        cal_rate_i = r;
        int_length_i = l;
        gain_word_i = g;
        set_broadcast_i = bc;
        set_strobe_i = 1'b1;
        @(negedge clock_i);
        set_strobe_i = 1'b0;
    endtask : put
    // start a window, count pulses, spacing and restorers
    task automatic burst(input int per, input int len);
        int n, gap, last, c, rst;
        n = 0; gap = 0; last = 0; c = 0; rst = 0;
        start_i = 1'b1;
        repeat (8000)
        begin
            @(negedge clock_i);
            start_i = 1'b0;
            c++;
            if ((cal_on_i ? cal_pulse_o : bunch_i) === 1'b1)
            begin
                gap = c - last; last = c; n++;
            end
            rst += (restore_o === 1'b1);
            if (c == 1) `CHK(burst_busy_o, cal_on_i)
            if (int_active_o !== 1'b1) break;
        end
        `CHK(n, len)
        if (cal_on_i && len > 1) `CHK(gap, per)
        if (cal_on_i) `CHK(rst, len)
    endtask : burst
    task automatic stop_test;
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    // a hang counts as a mismatch
    initial
    begin
        #1000000;
        failures++;
        stop_test();
    end
    initial
    begin
        repeat (10) @(negedge clock_i);
        reset_n_i = 1'b1;
        `CHK(cal_rate_o, `BCG_RATE_RST)
        `CHK(int_length_o, `BCG_INT_LEN_RST)
        `CHK(fo_gain_o, BCG_FO_UNITY)
        foreach (words[i])
        begin
            put(3'h0, 8'h03, words[i], 1'b0);
            `CHK({a_unity_en_o, a_tenth_en_o, b_unity_en_o, b_tenth_en_o,
                  tenfold_en_o}, words[i])
            `CHK({a_input_on_o, b_input_on_o},
                 {|words[i][4:3], |words[i][2:1]})
        end
        for (int f = 0; f < 4; f++)
        begin
            fo_gain_i = bcg_fo_gain_t'(f[1:0]);
            single_turn_i = f[0];
            put(3'h3, 8'h07, 5'h14, 1'b0);
            `CHK(fo_gain_o, fo_gain_i)
            `CHK(single_turn_gain_o, single_turn_i)
        end
        put(3'h5, 8'h00, 5'h14, 1'b0);
        `CHK(cal_rate_o, 3'h3)
        `CHK(int_length_o, 8'h07)
        shared_station_i = 1'b1;
        cal_on_i = 1'b1;
        put(3'h1, 8'h09, 5'h15, 1'b1);
        `CHK({cal_mode_o, cal_rate_o, int_length_o},
             {1'b0, 3'h3, 8'h07})
        put(3'h1, 8'h09, 5'h15, 1'b0);
        `CHK({cal_mode_o, cal_rate_o, int_length_o},
             {1'b1, 3'h1, 8'h09})
        shared_station_i = 1'b0;
        put(3'h0, 8'hff, 5'h14, 1'b1);
        burst(25, 255);
        put(3'h0, 8'h01, 5'h14, 1'b0);
        burst(25, 1);
        for (int r = 1; r < 5; r++)
        begin
            put(r[2:0], 8'h02, 5'h14, 1'b0);
            burst(25 << r, 2);
        end
        cal_on_i = 1'b0;
        put(3'h2, 8'h05, 5'h14, 1'b0);
        burst(0, 5);
        stop_test();
    end
endmodule : bcg_cal_gain_tb
